//--- dmacf_pkg.sv
// Constants shared by the channel enable and flag block
package dmacf_pkg;

	// Channel count and widths
	localparam int NUM_CHAN = 7;
	localparam int CHAN_IDX_W = 3;
	localparam int SFR_W = 8;
	localparam int OFFS_W = 10;

	// Register page and addresses
	localparam logic [7:0] DMA_PAGE = 8'h02;
	localparam logic [7:0] ADDR_CHAN_ENABLE = 8'hd2;
	localparam logic [7:0] ADDR_FULL_FLAGS = 8'hd3;
	localparam logic [7:0] ADDR_HALF_FLAGS = 8'hd4;
	localparam logic [7:0] ADDR_CHAN_CONFIG = 8'hc9;

	// Field positions inside the channel configuration register
	localparam int CFG_FULL_IE_BIT = 7;
	localparam int CFG_HALF_IE_BIT = 6;

	// Reset values
	localparam logic [6:0] CHAN_ENABLE_RST = 7'h00;
	localparam logic [6:0] FULL_FLAGS_RST = 7'h00;
	localparam logic [6:0] HALF_FLAGS_RST = 7'h00;
	localparam logic [6:0] CFG_IE_RST = 7'h00;
	localparam logic [9:0] OFFS_RST = 10'h000;
	localparam logic [7:0] RDATA_RST = 8'h00;

	// Selector value that names no channel
	localparam logic [2:0] SEL_INVALID = 3'h7;

	// Counting constants
	localparam logic [9:0] OFFS_ONE = 10'h001;
	localparam logic [0:0] UNUSED_BIT_READ = 1'h0;

endpackage

//--- dmacf_top.sv
// Per-channel enable, byte offset counters and completion flags of the DMA engine
`timescale 1ns/10ps
`default_nettype none

module dmacf_top
(
	input wire logic clock_i, // Core clock
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic [7:0] sfr_page_i, // Current register page
	input wire logic [7:0] sfr_addr_i, // Register address
	input wire logic sfr_wr_i, // Write strobe
	input wire logic sfr_rd_i, // Read strobe
	input wire logic [7:0] sfr_wdata_i, // Write data
	input wire logic [2:0] chan_sel_i, // Channel chosen for configuration
	input wire logic [6:0] byte_moved_i, // One pulse per byte moved, per channel
	input wire logic [6:0] offset_clr_i, // Counter clear from firmware, per channel
	input wire logic [6:0][9:0] transfer_size_i, // Programmed transfer size, per channel
	output logic [7:0] sfr_rdata_o, // Read data
	output logic sfr_rd_hit_o, // Read answered by this block
	output logic [6:0] chan_go_o, // Channel may transfer
	output logic [6:0][9:0] byte_offset_o, // Byte offset counters
	output logic [6:0] full_flags_o, // Full-length flags
	output logic [6:0] half_flags_o, // Mid-point flags
	output logic dma_irq_o // Interrupt request
);

	// Mid-point target for a given transfer size
	function automatic logic [9:0] half_target(input logic [9:0] size);
		logic [9:0] half;
		half = {1'b0, size[9:1]};
		if (size[0])
		begin
			half_target = half + dmacf_pkg::OFFS_ONE;
		end
		else
		begin
			half_target = half;
		end
	endfunction

	// Register access decode helper
	function automatic logic reg_hit(input logic [7:0] page, input logic [7:0] addr,
		input logic [7:0] want);
		reg_hit = (page == dmacf_pkg::DMA_PAGE) && (addr == want);
	endfunction

	// State
	logic [6:0] chan_enable_r;
	logic [6:0] chan_enable_nxt;
	logic [6:0] full_flags_r;
	logic [6:0] full_flags_nxt;
	logic [6:0] half_flags_r;
	logic [6:0] half_flags_nxt;
	logic [6:0] full_ie_r;
	logic [6:0] full_ie_nxt;
	logic [6:0] half_ie_r;
	logic [6:0] half_ie_nxt;
	logic [6:0][9:0] offs_r;
	logic [6:0][9:0] offs_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic rd_hit_r;
	logic rd_hit_nxt;
	logic [6:0] go_r;
	logic [6:0] go_nxt;
	logic irq_r;
	logic irq_nxt;

	// Address decode
	wire logic hit_en;
	wire logic hit_full;
	wire logic hit_half;
	wire logic hit_cfg;
	wire logic wr_en;
	wire logic wr_full;
	wire logic wr_half;
	wire logic wr_cfg;
	wire logic sel_valid;

	assign hit_en = reg_hit(sfr_page_i, sfr_addr_i, dmacf_pkg::ADDR_CHAN_ENABLE);
	assign hit_full = reg_hit(sfr_page_i, sfr_addr_i, dmacf_pkg::ADDR_FULL_FLAGS);
	assign hit_half = reg_hit(sfr_page_i, sfr_addr_i, dmacf_pkg::ADDR_HALF_FLAGS);
	assign hit_cfg = reg_hit(sfr_page_i, sfr_addr_i, dmacf_pkg::ADDR_CHAN_CONFIG);
	assign wr_en = sfr_wr_i && hit_en;
	assign wr_full = sfr_wr_i && hit_full;
	assign wr_half = sfr_wr_i && hit_half;
	assign wr_cfg = sfr_wr_i && hit_cfg;
	assign sel_valid = (chan_sel_i != dmacf_pkg::SEL_INVALID);

	// Per-channel compare events
	wire logic [6:0] full_set;
	wire logic [6:0] half_set;
	wire logic [6:0] cfg_wr_ch;

	// Channel slices: counters, compares and configuration enables
	genvar ch;
	generate
		for (ch = 0; ch < dmacf_pkg::NUM_CHAN; ch = ch + 1)
		begin : g_chan
			wire logic [9:0] full_tgt;
			wire logic [9:0] half_tgt;

			// Compare targets from the programmed size
			assign full_tgt = transfer_size_i[ch] - dmacf_pkg::OFFS_ONE;
			assign half_tgt = half_target(transfer_size_i[ch]);

			// Flag events on the byte that sits at the target offset
			assign full_set[ch] = byte_moved_i[ch] && (offs_r[ch] == full_tgt);
			assign half_set[ch] = byte_moved_i[ch] && (offs_r[ch] == half_tgt);

			// Configuration write aimed at this channel
			assign cfg_wr_ch[ch] = wr_cfg && sel_valid && (chan_sel_i == 3'(ch));

			// Offset counter: firmware clear, else one step per byte
			always_comb
			begin
				if (offset_clr_i[ch])
				begin
					offs_nxt[ch] = dmacf_pkg::OFFS_RST;
				end
				else if (byte_moved_i[ch])
				begin
					offs_nxt[ch] = offs_r[ch] + dmacf_pkg::OFFS_ONE;
				end
				else
				begin
					offs_nxt[ch] = offs_r[ch];
				end
			end

			// Interrupt enables taken from the selected channel's configuration
			always_comb
			begin
				if (cfg_wr_ch[ch])
				begin
					full_ie_nxt[ch] = sfr_wdata_i[dmacf_pkg::CFG_FULL_IE_BIT];
					half_ie_nxt[ch] = sfr_wdata_i[dmacf_pkg::CFG_HALF_IE_BIT];
				end
				else
				begin
					full_ie_nxt[ch] = full_ie_r[ch];
					half_ie_nxt[ch] = half_ie_r[ch];
				end
			end
		end
	endgenerate

	// Enable register: only bits 6 to 0 are stored
	assign chan_enable_nxt = wr_en ? sfr_wdata_i[6:0] : chan_enable_r;

	// Flag registers: a hardware set wins over a firmware write in the same cycle
	assign full_flags_nxt = (wr_full ? sfr_wdata_i[6:0] : full_flags_r) | full_set;
	assign half_flags_nxt = (wr_half ? sfr_wdata_i[6:0] : half_flags_r) | half_set;

	// Channel permission: enabled and no pending flag
	assign go_nxt = chan_enable_nxt & ~full_flags_nxt & ~half_flags_nxt;

	// Interrupt request from enabled flags
	assign irq_nxt = |((full_flags_nxt & full_ie_nxt) | (half_flags_nxt & half_ie_nxt));

	// Read data selection; bit 7 always zero
	wire logic rd_any;
	assign rd_any = sfr_rd_i && (hit_en || hit_full || hit_half);
	assign rd_hit_nxt = rd_any;
	always_comb
	begin
		rdata_nxt = dmacf_pkg::RDATA_RST;
		if (sfr_rd_i && hit_en)
		begin
			rdata_nxt = {dmacf_pkg::UNUSED_BIT_READ, chan_enable_r};
		end
		else if (sfr_rd_i && hit_full)
		begin
			rdata_nxt = {dmacf_pkg::UNUSED_BIT_READ, full_flags_r};
		end
		else if (sfr_rd_i && hit_half)
		begin
			rdata_nxt = {dmacf_pkg::UNUSED_BIT_READ, half_flags_r};
		end
		else
		begin
			rdata_nxt = dmacf_pkg::RDATA_RST;
		end
	end

	// Register file and flags
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			chan_enable_r <= dmacf_pkg::CHAN_ENABLE_RST;
			full_flags_r <= dmacf_pkg::FULL_FLAGS_RST;
			half_flags_r <= dmacf_pkg::HALF_FLAGS_RST;
			full_ie_r <= dmacf_pkg::CFG_IE_RST;
			half_ie_r <= dmacf_pkg::CFG_IE_RST;
		end
		else
		begin
			chan_enable_r <= chan_enable_nxt;
			full_flags_r <= full_flags_nxt;
			half_flags_r <= half_flags_nxt;
			full_ie_r <= full_ie_nxt;
			half_ie_r <= half_ie_nxt;
		end
	end

	// Offset counters
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			offs_r <= {dmacf_pkg::NUM_CHAN{dmacf_pkg::OFFS_RST}};
		end
		else
		begin
			offs_r <= offs_nxt;
		end
	end

	// Output stage
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			rdata_r <= dmacf_pkg::RDATA_RST;
			rd_hit_r <= 1'b0;
			go_r <= dmacf_pkg::CHAN_ENABLE_RST;
			irq_r <= 1'b0;
		end
		else
		begin
			rdata_r <= rdata_nxt;
			rd_hit_r <= rd_hit_nxt;
			go_r <= go_nxt;
			irq_r <= irq_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign sfr_rdata_o = rdata_r;
	assign sfr_rd_hit_o = rd_hit_r;
	assign chan_go_o = go_r;
	assign byte_offset_o = offs_r;
	assign full_flags_o = full_flags_r;
	assign half_flags_o = half_flags_r;
	assign dma_irq_o = irq_r;

endmodule

`default_nettype wire

//--- dmacf_sva.sv
// Checker for the channel enable and flag block
`timescale 1ns/10ps
`default_nettype none
module dmacf_sva
(
	input wire logic clock_i, // Clock
	input wire logic rst_i, // Reset
	input wire logic [7:0] sfr_page_i, // Page
	input wire logic [7:0] sfr_addr_i, // Address
	input wire logic sfr_wr_i, // Write
	input wire logic sfr_rd_i, // Read
	input wire logic [7:0] sfr_wdata_i, // Data in
	input wire logic [6:0] byte_moved_i, // Bytes
	input wire logic [6:0] offset_clr_i, // Clears
	input wire logic [6:0][9:0] transfer_size_i, // Sizes
	input wire logic [7:0] sfr_rdata_o, // Data out
	input wire logic sfr_rd_hit_o, // Hit
	input wire logic [6:0] chan_go_o, // Go
	input wire logic [6:0][9:0] byte_offset_o, // Offsets
	input wire logic [6:0] full_flags_o, // Full
	input wire logic [6:0] half_flags_o, // Half
	input wire logic dma_irq_o // Request
);
	// Decoded bus cycles and channel 0 targets
	wire pg = sfr_page_i == 8'h02;
	wire wf = sfr_wr_i && pg && sfr_addr_i == 8'hd3;
	wire [9:0] sz = transfer_size_i[0];
	wire [9:0] of = byte_offset_o[0];
	wire mv = byte_moved_i[0] && !offset_clr_i[0];
	wire hm = of == (sz >> 1) + {9'h000, sz[0]};
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// Flag, counter and register relations
	property p_full; mv && of == sz - 10'h001 |=> full_flags_o[0]; endproperty
	a_full: assert property (p_full) else $error("full flag missed");
	property p_half; mv && hm |=> half_flags_o[0]; endproperty
	a_half: assert property (p_half) else $error("half flag missed");
	property p_cnt; mv |=> of == $past(of) + 10'h001; endproperty
	a_cnt: assert property (p_cnt) else $error("offset not stepped");
	property p_keep; !wf |=> (full_flags_o & $past(full_flags_o)) == $past(full_flags_o);
	endproperty
	a_keep: assert property (p_keep) else $error("full flag dropped");
	property p_hold; (chan_go_o & (full_flags_o | half_flags_o)) == 7'h00; endproperty
	a_hold: assert property (p_hold) else $error("go while flagged");
	property p_en; sfr_wr_i && pg && sfr_addr_i == 8'hd2 && !sfr_wdata_i[0] |=> !chan_go_o[0];
	endproperty
	a_en: assert property (p_en) else $error("disabled channel goes");
	property p_rd; sfr_rd_i && pg && sfr_addr_i inside {8'hd2, 8'hd3, 8'hd4}
		|=> sfr_rd_hit_o && !sfr_rdata_o[7]; endproperty
	a_rd: assert property (p_rd) else $error("bad register read");
	property p_miss; sfr_rd_i && !pg |=> !sfr_rd_hit_o && sfr_rdata_o == 8'h00; endproperty
	a_miss: assert property (p_miss) else $error("answer off page");
	property p_irq; (full_flags_o | half_flags_o) == 7'h00 |-> !dma_irq_o; endproperty
	a_irq: assert property (p_irq) else $error("request without flag");
	// Main scenarios reached
	c_full: cover property (mv && of == sz - 10'h001);
	c_half: cover property (mv && hm);
	c_miss: cover property (sfr_rd_i && !pg);
endmodule
bind dmacf_top dmacf_sva u_sva (.*);
`default_nettype wire

//--- dmacf_mover.sv
// Far-side mover that moves bytes while a channel may go
`timescale 1ns/10ps
`default_nettype none
module dmacf_mover
(
	input wire logic clock_i, // Clock
	input wire logic [6:0] req_i, // Wanted bytes
	input wire logic [6:0] go_i, // Channel may go
	output logic [6:0] byte_moved_o // One byte each
);
	// Idle until the first falling edge
	initial byte_moved_o = 7'h00;
	// Only a permitted channel moves, one byte a cycle
	always @(negedge clock_i) byte_moved_o <= req_i & go_i;
endmodule
`default_nettype wire

//--- tb_dma_channel_enable_and_flags.sv
// Self-checking bench for the channel enable and flag block
`timescale 1ns/10ps
`default_nettype none
module tb_dma_channel_enable_and_flags;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] pg = 8'h02, addr = 8'h00, wd = 8'h00, rdat, cf;
	logic wr = 1'b0, rd = 1'b0, hit, irq;
	logic [2:0] sel = 3'h7;
	logic [6:0] req = 7'h00, clr = 7'h00, mv, go, ff, hf;
	logic [6:0][9:0] size = '0, offs;
	logic [31:0] seed = 32'h0000_11b8;
	int miscompares = 0, n_checks = 0, c, s;
	// Clock, design and mover
	always #5 clock_i = ~clock_i;
	dmacf_top dut (.clock_i(clock_i), .rst_i(rst_i), .sfr_page_i(pg), .sfr_addr_i(addr),
		.sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wd), .chan_sel_i(sel), .byte_moved_i(mv),
		.offset_clr_i(clr), .transfer_size_i(size), .sfr_rdata_o(rdat), .sfr_rd_hit_o(hit),
		.chan_go_o(go), .byte_offset_o(offs), .full_flags_o(ff), .half_flags_o(hf),
		.dma_irq_o(irq));
	dmacf_mover u_mover (.clock_i(clock_i), .req_i(req), .go_i(go), .byte_moved_o(mv));
	function logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	function int mid(input int n);
		return n / 2 + n % 2;
	endfunction
	task chk(input logic [15:0] g, e);
		n_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task complete_run;
		if (miscompares == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task wreg(input logic [7:0] a, d);
		@(negedge clock_i);
		wr = 1'b1;
		addr = a;
		wd = d;
		@(negedge clock_i);
		wr = 1'b0;
	endtask
	task rreg(input logic [7:0] p, a, e, input logic h);
		@(negedge clock_i);
		pg = p;
		rd = 1'b1;
		addr = a;
		@(negedge clock_i);
		rd = 1'b0;
		pg = 8'h02;
		chk(rdat, e);
		chk(hit, h);
	endtask
	// Bounded wait for all half or all full flags
	task waitf(input logic h);
		int i;
		i = 0;
		while (i < 300 && (h ? hf : ff) !== 7'h7f)
		begin
			i++;
			@(negedge clock_i);
		end
		if (i == 300)
		begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, h ? hf : ff, 7'h7f);
			complete_run;
		end
	endtask
	// Main sequence
	initial
	begin
		repeat (10) @(negedge clock_i);
		rst_i = 1'b0;
		for (logic [7:0] a = 8'hd2; a < 8'hd5; a++)
			rreg(8'h02, a, 8'h00, 1'b1);
		rreg(8'h00, 8'hd3, 8'h00, 1'b0);
		rreg(8'h02, 8'hd5, 8'h00, 1'b0);
		wreg(8'hd2, 8'hff);
		rreg(8'h02, 8'hd2, 8'h7f, 1'b1);
		repeat (3)
		begin
			seed = xs(seed);
			s = 4 + seed % 32;
			c = seed[15:8] % 7;
			size = {7{s[9:0]}};
			clr = 7'h7f;
			sel = 3'h7;
			wreg(8'hc9, 8'hc0);
			sel = c[2:0];
			// Random interrupt enables, never both off
			cf = {seed[23] | seed[22], ~seed[23], 6'h00};
			wreg(8'hc9, cf);
			clr = 7'h00;
			req = 7'h7f;
			waitf(1'b1);
			chk(offs[c], mid(s) + 1);
			chk(ff, 7'h00);
			chk(go, 7'h00);
			chk(irq, cf[6]);
			wreg(8'hd4, 8'h00);
			waitf(1'b0);
			chk(offs[c], s);
			chk(irq, cf[7]);
			req = 7'h00;
			rreg(8'h02, 8'hd3, 8'h7f, 1'b1);
			wreg(8'hd3, 8'h00);
			chk(irq, 1'b0);
			wreg(8'hc9, 8'h00);
		end
		wreg(8'hd2, 8'h00);
		chk(go, 7'h00);
		complete_run;
	end
endmodule
`default_nettype wire
